// ### idcr_defs.svh
`ifndef IDCR_DEFS_SVH
`define IDCR_DEFS_SVH

// byte offsets of the three identity words
`define IDCR_OFF_REV 12'h000
`define IDCR_OFF_PART 12'h004
`define IDCR_OFF_MEM 12'h008

// revision word layout
`define IDCR_FMT0_HI 30
`define IDCR_FMT0_LO 28
`define IDCR_MAJ_HI 15
`define IDCR_MAJ_LO 8
`define IDCR_MIN_HI 7
`define IDCR_MIN_LO 0

// part word layout
`define IDCR_FMT1_HI 31
`define IDCR_FMT1_LO 28
`define IDCR_LINE_HI 27
`define IDCR_LINE_LO 24
`define IDCR_DEVN_HI 23
`define IDCR_DEVN_LO 16
`define IDCR_THERM_HI 7
`define IDCR_THERM_LO 5
`define IDCR_HOUS_HI 4
`define IDCR_HOUS_LO 3
`define IDCR_HAZ_BIT 2
`define IDCR_GRADE_HI 1
`define IDCR_GRADE_LO 0

// memory word layout
`define IDCR_RAM_HI 31
`define IDCR_RAM_LO 16
`define IDCR_NVM_HI 15
`define IDCR_NVM_LO 0

// reserved spans of the identity words
`define IDCR_RSVD0_BIT 31
`define IDCR_RSVD0_HI 27
`define IDCR_RSVD0_LO 16
`define IDCR_RSVD1_HI 15
`define IDCR_RSVD1_LO 8
`define IDCR_RSVD0_VAL 12'h000
`define IDCR_RSVD1_VAL 8'h00

// fixed field values
`define IDCR_FMT0_VAL 3'h0
`define IDCR_FMT1_VAL 4'h0
`define IDCR_THERM_IND 3'h1
`define IDCR_HOUS_QFP48 2'h1
`define IDCR_HAZ_YES 1'h1
`define IDCR_GRADE_ENG 2'h0
`define IDCR_GRADE_PILOT 2'h1
`define IDCR_GRADE_RELEASE_GRADE 2'h2
`define IDCR_GRADE_RSVD 2'h3
`define IDCR_RAM_SIZE 16'h001F
`define IDCR_NVM_SIZE 16'h000F
`define IDCR_WORD_ZERO 32'h0000_0000

`endif

// ### idcr_pkg.sv
package idcr_pkg;

    // bus answer sequencer
    typedef enum logic {
        IDCR_ACC_IDLE = 1'b0,
        IDCR_ACC_DONE = 1'b1
    } idcr_acc_type;

    // which word an access hit
    typedef enum logic [1:0] {
        IDCR_REG_REV = 2'b00,
        IDCR_REG_PART = 2'b01,
        IDCR_REG_MEM = 2'b10,
        IDCR_REG_NONE = 2'b11
    } idcr_reg_type;

    // whole state of the bus slave
    typedef struct packed {
        idcr_acc_type acc;
        idcr_reg_type hit;
        logic was_write;
        logic ready;
        logic slverr;
        logic [31:0] rdata;
    } idcr_state_type;

endpackage

// ### idcr_word_pack.sv
`timescale 1ns/10ps
`include "idcr_defs.svh"

module idcr_word_pack #(
    // revision letter, value is arbitrary
    parameter logic [7:0] MAJOR_REV = 8'h01,
    // interconnect changes, value is arbitrary
    parameter logic [7:0] MINOR_REV = 8'h01,
    // product line code, value is arbitrary
    parameter logic [3:0] PRODUCT_LINE = 4'h5,
    // device number, value is arbitrary
    parameter logic [7:0] DEVICE_NUMBER = 8'h5A,
    parameter logic [1:0] RELEASE_GRADE = 2'h2,
    parameter logic [15:0] RAM_SIZE = `IDCR_RAM_SIZE,
    parameter logic [15:0] NVM_SIZE = `IDCR_NVM_SIZE
) (
    output logic [31:0] rev_word,
    output logic [31:0] part_word,
    output logic [31:0] mem_word
);

    // a reserved grade strap would mislead software, so report it unqualified
    logic [1:0] grade;
    assign grade = (RELEASE_GRADE == `IDCR_GRADE_RSVD) ?
                   `IDCR_GRADE_ENG : RELEASE_GRADE;

    // revision word, reserved bits zero
    always_comb begin
        rev_word = `IDCR_WORD_ZERO;
        rev_word[`IDCR_FMT0_HI:`IDCR_FMT0_LO] = `IDCR_FMT0_VAL;
        rev_word[`IDCR_MAJ_HI:`IDCR_MAJ_LO] = MAJOR_REV;
        rev_word[`IDCR_MIN_HI:`IDCR_MIN_LO] = MINOR_REV;
    end

    // part word, reserved bits zero
    always_comb begin
        part_word = `IDCR_WORD_ZERO;
        part_word[`IDCR_FMT1_HI:`IDCR_FMT1_LO] = `IDCR_FMT1_VAL;
        part_word[`IDCR_LINE_HI:`IDCR_LINE_LO] = PRODUCT_LINE;
        part_word[`IDCR_DEVN_HI:`IDCR_DEVN_LO] = DEVICE_NUMBER;
        part_word[`IDCR_THERM_HI:`IDCR_THERM_LO] = `IDCR_THERM_IND;
        part_word[`IDCR_HOUS_HI:`IDCR_HOUS_LO] = `IDCR_HOUS_QFP48;
        part_word[`IDCR_HAZ_BIT] = `IDCR_HAZ_YES;
        part_word[`IDCR_GRADE_HI:`IDCR_GRADE_LO] = grade;
    end

    // memory size word
    always_comb begin
        mem_word = `IDCR_WORD_ZERO;
        mem_word[`IDCR_RAM_HI:`IDCR_RAM_LO] = RAM_SIZE;
        mem_word[`IDCR_NVM_HI:`IDCR_NVM_LO] = NVM_SIZE;
    end

endmodule // idcr_word_pack

// ### idcr_regs.sv
// Chosen here: the APB register port.
`timescale 1ns/10ps
`include "idcr_defs.svh"

module idcr_regs #(
    parameter int ADDR_W = 12,
    // revision letter, arbitrary default
    parameter logic [7:0] MAJOR_REV = 8'h01,
    // interconnect changes, arbitrary default
    parameter logic [7:0] MINOR_REV = 8'h01,
    // product line code, value is arbitrary
    parameter logic [3:0] PRODUCT_LINE = 4'h5,
    // device number, value is arbitrary
    parameter logic [7:0] DEVICE_NUMBER = 8'h5A,
    // qualification status of the silicon
    parameter logic [1:0] RELEASE_GRADE = 2'h2,
    parameter logic [15:0] RAM_SIZE = `IDCR_RAM_SIZE,
    parameter logic [15:0] NVM_SIZE = `IDCR_NVM_SIZE
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CLK_EN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);

    // registered slave state and its next value
    idcr_pkg::idcr_state_type state;
    idcr_pkg::idcr_state_type next_state;

    // fixed words from the packer
    logic [31:0] rev_word;
    logic [31:0] part_word;
    logic [31:0] mem_word;

    // address decode results
    idcr_pkg::idcr_reg_type dec_hit;
    logic [31:0] dec_word;

    // state after reset: idle, bus quiet
    localparam idcr_pkg::idcr_state_type RESET_STATE = '{
        acc: idcr_pkg::IDCR_ACC_IDLE,
        hit: idcr_pkg::IDCR_REG_NONE,
        was_write: 1'b0,
        ready: 1'b0,
        slverr: 1'b0,
        rdata: `IDCR_WORD_ZERO
    };

    // constant words; no storage, so no write can disturb them
    idcr_word_pack #(
        .MAJOR_REV(MAJOR_REV),
        .MINOR_REV(MINOR_REV),
        .PRODUCT_LINE(PRODUCT_LINE),
        .DEVICE_NUMBER(DEVICE_NUMBER),
        .RELEASE_GRADE(RELEASE_GRADE),
        .RAM_SIZE(RAM_SIZE),
        .NVM_SIZE(NVM_SIZE)
    ) u_pack (
        .rev_word(rev_word),
        .part_word(part_word),
        .mem_word(mem_word)
    );

    // full-address compare, so unaligned offsets fall to the error path
    always_comb begin
        dec_hit = idcr_pkg::IDCR_REG_NONE;
        dec_word = `IDCR_WORD_ZERO;
        // revision word
        if (PADDR == ADDR_W'(`IDCR_OFF_REV)) begin
            dec_hit = idcr_pkg::IDCR_REG_REV;
            dec_word = rev_word;
        end
        // part word
        else if (PADDR == ADDR_W'(`IDCR_OFF_PART)) begin
            dec_hit = idcr_pkg::IDCR_REG_PART;
            dec_word = part_word;
        end
        // memory size word
        else if (PADDR == ADDR_W'(`IDCR_OFF_MEM)) begin
            dec_hit = idcr_pkg::IDCR_REG_MEM;
            dec_word = mem_word;
        end
    end

    // answer sequencer: one wait state, so PRDATA leaves a flop
    always_comb begin
        next_state = state;
        case (state.acc)
            // wait for the access phase
            idcr_pkg::IDCR_ACC_IDLE: begin
                next_state.ready = 1'b0;
                next_state.slverr = 1'b0;
                next_state.rdata = `IDCR_WORD_ZERO;
                if (PSEL && PENABLE) begin
                    next_state.acc = idcr_pkg::IDCR_ACC_DONE;
                    next_state.hit = dec_hit;
                    next_state.was_write = PWRITE;
                    next_state.ready = 1'b1;
                    // unmapped offset answers with an error
                    next_state.slverr =
                        (dec_hit == idcr_pkg::IDCR_REG_NONE);
                    // writes return zero and change nothing
                    if (PWRITE) begin
                        next_state.rdata = `IDCR_WORD_ZERO;
                    end
                    else begin
                        next_state.rdata = dec_word;
                    end
                end
            end
            // master takes the answer at this edge
            idcr_pkg::IDCR_ACC_DONE: begin
                next_state.acc = idcr_pkg::IDCR_ACC_IDLE;
                next_state.hit = idcr_pkg::IDCR_REG_NONE;
                next_state.was_write = 1'b0;
                next_state.ready = 1'b0;
                next_state.slverr = 1'b0;
                next_state.rdata = `IDCR_WORD_ZERO;
            end
            // unreachable code point, recover to idle
            default: begin
                next_state = RESET_STATE;
            end
        endcase
    end

    // state register; a low enable freezes everything but reset
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            state <= RESET_STATE;
        end
        else if (CLK_EN) begin
            state <= next_state;
        end
    end

    // outputs straight from the state flops
    assign PRDATA = state.rdata;
    assign PREADY = state.ready;
    assign PSLVERR = state.slverr;

    // all checks share one clock; all but reset_quiet_a are disabled by the system reset
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    // read of each word completing at this edge
    sequence rd_rev_done;
        PREADY && PSEL && PENABLE && !PWRITE &&
        (PADDR == ADDR_W'(`IDCR_OFF_REV));
    endsequence

    sequence rd_part_done;
        PREADY && PSEL && PENABLE && !PWRITE &&
        (PADDR == ADDR_W'(`IDCR_OFF_PART));
    endsequence

    sequence rd_mem_done;
        PREADY && PSEL && PENABLE && !PWRITE &&
        (PADDR == ADDR_W'(`IDCR_OFF_MEM));
    endsequence

    // access phase seen while not yet answering
    sequence access_start;
        PSEL && PENABLE && !PREADY && CLK_EN;
    endsequence

    // write to a mapped word being answered
    sequence wr_mapped_done;
        PREADY && PSEL && PENABLE && PWRITE &&
        ((PADDR == ADDR_W'(`IDCR_OFF_REV)) ||
         (PADDR == ADDR_W'(`IDCR_OFF_PART)) ||
         (PADDR == ADDR_W'(`IDCR_OFF_MEM)));
    endsequence

    // setup cycle of a transfer, slave idle
    sequence setup_phase;
        PSEL && !PENABLE && !PREADY;
    endsequence

    // enabled access phase right after the setup
    sequence enabled_access;
        PSEL && PENABLE && CLK_EN;
    endsequence

    // reserved bits of the revision word
    rsvd_bits_zero_a: assert property (
        rd_rev_done |-> (PRDATA[`IDCR_RSVD0_BIT] == 1'b0) &&
            (PRDATA[`IDCR_RSVD0_HI:`IDCR_RSVD0_LO] == `IDCR_RSVD0_VAL))
        else $error("reserved revision bits not zero");

    // format version of the revision word
    fmt0_zero_a: assert property (
        rd_rev_done |->
            PRDATA[`IDCR_FMT0_HI:`IDCR_FMT0_LO] == `IDCR_FMT0_VAL)
        else $error("revision word format version not zero");

    // format version of the part word
    fmt1_zero_a: assert property (
        rd_part_done |->
            PRDATA[`IDCR_FMT1_HI:`IDCR_FMT1_LO] == `IDCR_FMT1_VAL)
        else $error("part word format version not zero");

    // major revision letter code
    major_rev_a: assert property (
        rd_rev_done |->
            PRDATA[`IDCR_MAJ_HI:`IDCR_MAJ_LO] == MAJOR_REV)
        else $error("major revision field wrong");

    // interconnect change count
    minor_rev_a: assert property (
        rd_rev_done |->
            PRDATA[`IDCR_MIN_HI:`IDCR_MIN_LO] == MINOR_REV)
        else $error("minor revision field wrong");

    // product line code
    line_code_a: assert property (
        rd_part_done |->
            PRDATA[`IDCR_LINE_HI:`IDCR_LINE_LO] == PRODUCT_LINE)
        else $error("product line code wrong");

    // device number within the line
    dev_number_a: assert property (
        rd_part_done |->
            PRDATA[`IDCR_DEVN_HI:`IDCR_DEVN_LO] == DEVICE_NUMBER)
        else $error("device number wrong");

    // thermal grade
    thermal_grade_a: assert property (
        rd_part_done |->
            PRDATA[`IDCR_THERM_HI:`IDCR_THERM_LO] == `IDCR_THERM_IND)
        else $error("thermal grade not industrial");

    // housing type
    housing_type_a: assert property (
        rd_part_done |->
            PRDATA[`IDCR_HOUS_HI:`IDCR_HOUS_LO] == `IDCR_HOUS_QFP48)
        else $error("housing type wrong");

    // compliance flag
    hazard_flag_a: assert property (
        rd_part_done |-> PRDATA[`IDCR_HAZ_BIT] == `IDCR_HAZ_YES)
        else $error("compliance flag clear");

    // release grade never the reserved code
    release_grade_a: assert property (
        rd_part_done |->
            PRDATA[`IDCR_GRADE_HI:`IDCR_GRADE_LO] != `IDCR_GRADE_RSVD)
        else $error("release grade reads reserved code");

    // RAM size field
    ram_size_a: assert property (
        rd_mem_done |->
            PRDATA[`IDCR_RAM_HI:`IDCR_RAM_LO] == RAM_SIZE)
        else $error("RAM size field wrong");

    // flash size field
    nvm_size_a: assert property (
        rd_mem_done |->
            PRDATA[`IDCR_NVM_HI:`IDCR_NVM_LO] == NVM_SIZE)
        else $error("flash size field wrong");

    // write accepted without error, zero data returned, packer words unchanged
    write_ignored_a: assert property (
        wr_mapped_done |-> !PSLVERR && (PRDATA == `IDCR_WORD_ZERO) &&
            (u_pack.rev_word == $past(u_pack.rev_word)) &&
            (u_pack.part_word == $past(u_pack.part_word)) &&
            (u_pack.mem_word == $past(u_pack.mem_word)))
        else $error("write disturbed the slave");

    // every enabled access phase is answered one cycle later
    answer_time_a: assert property (
        access_start |=> PREADY)
        else $error("access phase not answered in one cycle");

    // ready is a single cycle while enabled
    ready_pulse_a: assert property (
        PREADY && CLK_EN |=> !PREADY && !PSLVERR)
        else $error("ready held past the completing edge");

    // unmapped offset answers with error and zero data
    unmapped_err_a: assert property (
        (access_start and (dec_hit == idcr_pkg::IDCR_REG_NONE)) |=>
            PSLVERR && (PRDATA == `IDCR_WORD_ZERO))
        else $error("unmapped access answered without error");

    // a low enable freezes every output
    freeze_a: assert property (
        !CLK_EN |=> $stable(PRDATA) && $stable(PREADY) &&
            $stable(PSLVERR))
        else $error("outputs moved while enable low");

    // no answer without an access phase before it
    no_stray_ready_a: assert property (
        $rose(PREADY) |-> $past(PSEL) && $past(PENABLE))
        else $error("ready rose without an access");

    // setup then enabled access: answer after one wait state
    setup_to_ready_a: assert property (
        setup_phase ##1 enabled_access |=> PREADY)
        else $error("transfer not answered after one wait state");

    // between answers the data and error lines stay at zero
    quiet_idle_a: assert property (
        !PREADY |-> !PSLVERR && (PRDATA == `IDCR_WORD_ZERO))
        else $error("data or error shown without ready");

    // reserved bits of the part word
    rsvd_part_zero_a: assert property (
        rd_part_done |->
            PRDATA[`IDCR_RSVD1_HI:`IDCR_RSVD1_LO] == `IDCR_RSVD1_VAL)
        else $error("reserved part bits not zero");

    // mapped reads never answer with an error
    read_no_err_a: assert property (
        (rd_rev_done or rd_part_done or rd_mem_done) |-> !PSLVERR)
        else $error("mapped read answered with error");

    // a legal grade strap is reported exactly
    grade_value_a: assert property (
        (rd_part_done and (RELEASE_GRADE != `IDCR_GRADE_RSVD)) |->
            PRDATA[`IDCR_GRADE_HI:`IDCR_GRADE_LO] == RELEASE_GRADE)
        else $error("release grade differs from its strap");

    // reset clears the answer whatever the enable does
    reset_quiet_a: assert property (disable iff (1'b0)
        !RST_N |=> !PREADY && !PSLVERR && (PRDATA == `IDCR_WORD_ZERO))
        else $error("outputs not cleared by reset");

endmodule // idcr_regs

// ### device_identity_capability_regs_tb_top.sv
`timescale 1ns/10ps
`include "idcr_defs.svh"

module device_identity_capability_regs_tb_top;
    // revision and part numbers chosen for the run, values are arbitrary
    localparam logic [7:0] MAJ = 8'h02;
    localparam logic [7:0] MIN = 8'h03;
    localparam logic [3:0] LINE = 4'hA;
    localparam logic [7:0] DEVN = 8'h3C;
    // cycle ceiling, far above the under 80 cycles the tests need
    localparam int LIMIT = 5000;

    logic clk_sys; // system clock, 4 ns period
    logic rst_n; // synchronous reset, active low
    logic clk_en; // clock enable shared by all instances
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata [4]; // one answer per release grade
    logic pready [4];
    logic pslverr [4];
    logic [31:0] rd [4]; // read data taken at the completing edge
    logic err [4];
    logic stand_rdy; // answer seen one cycle after completion
    logic stall_rdy; // any ready seen while the enable was low
    logic [31:0] stand_dat;
    int fails;
    int num_checks;
    int cycles;
    int stall; // cycles of clock enable low in the access phase
    int lat; // edges from access start, or from the end of a stall, to completion

    // four slaves differing only in release grade, all on one bus
    for (genvar g = 0; g < 4; g++) begin : grade_g
        idcr_regs #(
            .ADDR_W(12),
            .MAJOR_REV(MAJ),
            .MINOR_REV(MIN),
            .PRODUCT_LINE(LINE),
            .DEVICE_NUMBER(DEVN),
            .RELEASE_GRADE(2'(g))
        ) idcr_regs_i (
            .CLK_SYS(clk_sys),
            .RST_N(rst_n),
            .CLK_EN(clk_en),
            .PSEL(psel),
            .PENABLE(penable),
            .PWRITE(pwrite),
            .PADDR(paddr),
            .PWDATA(pwdata),
            .PRDATA(prdata[g]),
            .PREADY(pready[g]),
            .PSLVERR(pslverr[g])
        );
    end

    // clock generator
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // hang guard: ends the run as a failure
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails++;
            give_verdict();
        end
    end

    // expected word; reserved bits are taken to read zero
    function automatic logic [31:0] exp_word(input logic [11:0] a,
                                             input int g);
        logic [1:0] q;
        q = (g == 3) ? 2'h0 : 2'(g); // reserved grade never reported
        case (a)
            `IDCR_OFF_REV: exp_word = {1'h0, 3'h0, 12'h000, MAJ, MIN};
            `IDCR_OFF_PART: exp_word = {4'h0, LINE, DEVN, 8'h00, 3'h1,
                                        2'h1, 1'h1, q};
            `IDCR_OFF_MEM: exp_word = 32'h001F000F;
            default: exp_word = 32'h00000000;
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    // one apb transfer; caller stands just after a rising edge
    task automatic apb_xfer(input logic wr, input logic [11:0] a,
                            input logic [31:0] wd, input logic b2b);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        if (stall > 0) begin
            clk_en <= 1'b0;
            stall_rdy = 1'b0;
            repeat (stall) begin
                @(posedge clk_sys);
                stall_rdy = stall_rdy | pready[0];
            end
            clk_en <= 1'b1;
        end
        n = 0;
        // wait for the answer; only the hang guard ends a stuck wait
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready[0] !== 1'b1);
        lat = n;
        for (int i = 0; i < 4; i++) begin
            rd[i] = prdata[i];
            err[i] = pslverr[i];
        end
        if (!b2b) begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk_sys);
            stand_rdy = pready[0];
            stand_dat = prdata[0];
        end
    endtask

    // outputs quiet during a second reset applied mid-run
    task automatic test_reset();
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(32'({pready[0], pslverr[0]}), 32'h0);
        chk(prdata[0], 32'h0);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        $display("test reset done");
    endtask

    // every word of every grade, answer latency and hold time
    task automatic test_read();
        logic [11:0] offs [3];
        offs = '{`IDCR_OFF_REV, `IDCR_OFF_PART, `IDCR_OFF_MEM};
        foreach (offs[k]) begin
            apb_xfer(1'b0, offs[k], 32'h0, 1'b0);
            for (int g = 0; g < 4; g++) begin
                chk(rd[g], exp_word(offs[k], g));
                chk(32'(err[g]), 32'h0);
            end
            chk(lat, 2);
            chk(32'(stand_rdy), 32'h0);
            chk(stand_dat, 32'h0);
        end
        $display("test read done");
    endtask

    // back-to-back writes with all field bits set, then read back unchanged
    task automatic test_write();
        // field bits all ones, reserved bits kept at what they read
        apb_xfer(1'b1, `IDCR_OFF_REV, 32'h7000FFFF, 1'b1);
        chk(32'(err[0]), 32'h0);
        chk(rd[0], 32'h0);
        apb_xfer(1'b1, `IDCR_OFF_PART, 32'hFFFF00FF, 1'b1);
        chk(32'(err[0]), 32'h0);
        chk(rd[0], 32'h0);
        apb_xfer(1'b1, `IDCR_OFF_MEM, 32'hFFFFFFFF, 1'b0);
        chk(32'(err[0]), 32'h0);
        chk(rd[0], 32'h0);
        apb_xfer(1'b0, `IDCR_OFF_REV, 32'h0, 1'b1);
        chk(rd[0], exp_word(`IDCR_OFF_REV, 0));
        apb_xfer(1'b0, `IDCR_OFF_PART, 32'h0, 1'b1);
        chk(rd[1], exp_word(`IDCR_OFF_PART, 1));
        apb_xfer(1'b0, `IDCR_OFF_MEM, 32'h0, 1'b0);
        chk(rd[2], exp_word(`IDCR_OFF_MEM, 2));
        $display("test write done");
    endtask

    // unmapped and unaligned places answer with an error
    task automatic test_unmapped();
        logic [11:0] bad [4];
        bad = '{12'h00C, 12'h002, 12'h010, 12'hFFC};
        foreach (bad[k]) begin
            apb_xfer(1'(k), bad[k], 32'h12345678, 1'b1);
            chk(32'(err[0]), 32'h1);
            chk(rd[0], 32'h0);
        end
        apb_xfer(1'b0, `IDCR_OFF_MEM, 32'h0, 1'b0);
        chk(32'(err[0]), 32'h0);
        chk(rd[0], exp_word(`IDCR_OFF_MEM, 0));
        $display("test unmapped done");
    endtask

    // clock enable low in the access phase holds the answer back
    task automatic test_stall();
        stall = 3;
        apb_xfer(1'b0, `IDCR_OFF_PART, 32'h0, 1'b0);
        stall = 0;
        chk(rd[2], exp_word(`IDCR_OFF_PART, 2));
        chk(lat, 2);
        chk(32'(stall_rdy), 32'h0);
        $display("test stall done");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        fails = 0;
        num_checks = 0;
        cycles = 0;
        stall = 0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        test_read();
        test_write();
        test_unmapped();
        test_stall();
        test_reset();
        test_read();
        give_verdict();
    end
endmodule // device_identity_capability_regs_tb_top
